//--- hdl/timer_unit_consts.svh
// register offsets, field positions and reset values of the timer unit
`ifndef TIMER_UNIT_CONSTS_SVH
`define TIMER_UNIT_CONSTS_SVH
`define TU_ADDR_W 6
`define TU_OFS_MODE 6'h00
`define TU_OFS_IRQ_EN 6'h04
`define TU_OFS_FLAGS 6'h08
`define TU_OFS_OCCUPANCY 6'h0c
`define TU_OFS_TALLY 6'h10
`define TU_OFS_TERMINAL 6'h14
`define TU_OFS_QUEUE 6'h18
`define TU_OFS_XFER_CTL 6'h1c
`define TU_OFS_XFER_PTR 6'h20
`define TU_OFS_BUF_FIRST 6'h24
`define TU_OFS_BUF_LIMIT 6'h28
`define TU_CNT_W 26
`define TU_ADR_W 14
`define TU_Q_DEPTH 8
`define TU_Q_HALF 4'h4
`define TU_MODE_W 10
`define TU_MODE_RESET 10'h002
`define TU_B_INPUT 0
`define TU_B_FLUSH 1
`define TU_B_RUN 2
`define TU_B_OUT_ON 3
`define TU_B_POLARITY 4
`define TU_B_SUBMODE 5
`define TU_B_EDGE_LO 6
`define TU_B_REP_LO 8
`define TU_F_PERIOD 0
`define TU_F_LEVEL 1
`define TU_F_HALF 2
`define TU_F_XFER 3
`define TU_F_OVERRUN 4
`define TU_X_ON 0
`define TU_X_WRAP 2
`define TU_WORD_STEP 14'h0004
`endif

//--- hdl/timer_unit_pkg.sv
// types shared by the timer unit
package timer_unit_pkg;
	typedef enum logic [0:0] {
		xfer_idle = 1'b0,
		xfer_wait = 1'b1
	} xfer_state_t;
	typedef enum logic [1:0] {
		edge_none = 2'b00,
		edge_both = 2'b01,
		edge_fall = 2'b10,
		edge_rise = 2'b11
	} edge_sel_t;
endpackage : timer_unit_pkg

//--- hdl/timer_pwm_dma_unit.sv
// timer, edge counter and pwm generator with duty queue and refill engine
//
// Contract
// - terminal value keeps only its low 26 bits; upper bits ignored.
// - any write to the terminal value clears the current tally.
// - counter only counts up, intervals up to 2^26 clocks.
// - queue entries hold 26 bits; read in input modes, written in timing and pwm modes.
// - timing mode sets period flag when tally equals terminal; write 1 clears.
// - timing period equals clock period times terminal value.
// - counting mode at final count sets flag, zeroes tally, may interrupt.
// - counting mode counts input pin edges chosen by the edge field.
// - flush bit empties queue, clears tally and flags until cleared.
// - active length equals duty; zero gives 0%, terminal gives 100%.
// - polarity bit selects idle high or idle low output.
// - active level adjustable in single clock steps.
// - repeat field 00/01/10/11 reuses a duty for 1/4/8/16 periods.
// - after the repeats the next duty is popped with no gap.
// - waveform reaches the pin only with run and output enable both set.
// - level end and period end set flags and interrupt when enabled.
// - refill engine only on instances with it; control bit 0 enables it.
// - with wrap bit 2 set, reaching the limit reloads the first address.
// - buffer addresses use low 14 bits, word aligned, limit exclusive.
// - transfer pointer steps by 4 bytes per word fetched.
// - each instance drives its own interrupt line.
// - polarity 0 idles low active high; 1 idles high active low.
// - queue holds at most 8 entries; occupancy readable.
// - pwm sets overrun when queue empty, half when below 4; write 1 clears.
// - engine sets completion flag when buffer finishes; write 1 clears.
`timescale 1ns/100ps
`include "timer_unit_consts.svh"

module timer_pwm_dma_unit #(
	parameter bit HAS_XFER = 1'b1
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [`TU_ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic count_pin_in,
	output logic wave_pin_out,
	output logic wave_pin_oe,
	output logic mem_rd,
	output logic [`TU_ADR_W-1:0] mem_addr,
	input wire logic mem_valid,
	input wire logic [31:0] mem_rdata,
	output logic irq
);
	logic [`TU_MODE_W-1:0] mode_control;
	logic [4:0] irq_enable_register;
	logic [4:0] flag_register;
	logic [`TU_CNT_W-1:0] current_tally;
	logic [`TU_CNT_W-1:0] terminal_value;
	logic [2:0] transfer_control;
	logic [`TU_ADR_W-1:0] transfer_pointer;
	logic [`TU_ADR_W-1:0] buffer_first;
	logic [`TU_ADR_W-1:0] buffer_limit;
	logic [`TU_CNT_W-1:0] queue_mem [`TU_Q_DEPTH];
	logic [2:0] q_wr_ptr;
	logic [2:0] q_rd_ptr;
	logic [3:0] queue_occupancy;
	logic [`TU_CNT_W-1:0] duty;
	logic duty_valid;
	logic [3:0] rep_cnt;
	logic [3:0] rep_limit;
	logic pin_s1, pin_s2, pin_s3, pin_stable;
	logic xfer_stopped;
	timer_unit_pkg::xfer_state_t xfer_state;
	timer_unit_pkg::edge_sel_t edge_sel;

	logic input_mode, flush, run, out_on, polarity, count_mode, pwm_mode;
	logic wr_mode, wr_irq_en, wr_flags, wr_term, wr_queue, wr_xctl, wr_first, wr_limit;
	logic rd_queue;
	logic q_full, q_empty, q_push, q_pop;
	logic [`TU_CNT_W-1:0] q_push_data;
	logic pin_rise, pin_fall, count_edge;
	logic period_hit, count_hit, level_hit, rep_done, load_now, overrun_hit;
	logic xfer_push, xfer_last, xfer_issue;
	logic [`TU_ADR_W-1:0] next_pointer;
	logic [4:0] flag_set;
	logic active_level;

	assign input_mode = mode_control[`TU_B_INPUT];
	assign flush = mode_control[`TU_B_FLUSH];
	assign run = mode_control[`TU_B_RUN] && !flush;
	assign out_on = mode_control[`TU_B_OUT_ON];
	assign polarity = mode_control[`TU_B_POLARITY];
	assign count_mode = input_mode && mode_control[`TU_B_SUBMODE];
	assign pwm_mode = !input_mode && out_on;
	assign edge_sel = timer_unit_pkg::edge_sel_t'(mode_control[`TU_B_EDGE_LO +: 2]);

	assign wr_mode = reg_wr && reg_addr == `TU_OFS_MODE;
	assign wr_irq_en = reg_wr && reg_addr == `TU_OFS_IRQ_EN;
	assign wr_flags = reg_wr && reg_addr == `TU_OFS_FLAGS;
	assign wr_term = reg_wr && reg_addr == `TU_OFS_TERMINAL;
	assign wr_queue = reg_wr && reg_addr == `TU_OFS_QUEUE;
	assign wr_xctl = HAS_XFER && reg_wr && reg_addr == `TU_OFS_XFER_CTL;
	assign wr_first = HAS_XFER && reg_wr && reg_addr == `TU_OFS_BUF_FIRST;
	assign wr_limit = HAS_XFER && reg_wr && reg_addr == `TU_OFS_BUF_LIMIT;
	assign rd_queue = reg_rd && reg_addr == `TU_OFS_QUEUE;

	// control registers
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mode_control <= `TU_MODE_RESET;
			irq_enable_register <= 5'h00;
			terminal_value <= 26'h0000000;
		end else begin
			if (wr_mode)
				mode_control <= reg_wdata[`TU_MODE_W-1:0];
			if (wr_irq_en)
				irq_enable_register <= reg_wdata[4:0];
			if (wr_term)
				terminal_value <= reg_wdata[`TU_CNT_W-1:0];
		end
	end

	// pin synchroniser, change accepted when second and third stages agree
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pin_s1 <= 1'b0;
			pin_s2 <= 1'b0;
			pin_s3 <= 1'b0;
			pin_stable <= 1'b0;
		end else begin
			pin_s1 <= count_pin_in;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			if (pin_s2 == pin_s3)
				pin_stable <= pin_s3;
		end
	end

	assign pin_rise = pin_s2 == pin_s3 && pin_s3 && !pin_stable;
	assign pin_fall = pin_s2 == pin_s3 && !pin_s3 && pin_stable;

	always_comb begin
		case (edge_sel)
			timer_unit_pkg::edge_both: count_edge = pin_rise || pin_fall;
			timer_unit_pkg::edge_fall: count_edge = pin_fall;
			timer_unit_pkg::edge_rise: count_edge = pin_rise;
			default: count_edge = 1'b0;
		endcase
	end

	assign period_hit = run && !input_mode && current_tally == terminal_value;
	assign count_hit = run && count_mode && count_edge
		&& current_tally == terminal_value + 26'h0000001;

	// tally: timing and pwm run 1..terminal, counting runs 0..terminal+1 and wraps on the next edge
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			current_tally <= 26'h0000000;
		else if (flush || wr_term)
			current_tally <= 26'h0000000;
		else if (run && !input_mode)
			current_tally <= period_hit ? 26'h0000001 : current_tally + 26'h0000001;
		else if (run && count_mode && count_edge)
			current_tally <= count_hit ? 26'h0000000 : current_tally + 26'h0000001;
	end

	// duty queue
	assign q_full = queue_occupancy == 4'(`TU_Q_DEPTH);
	assign q_empty = queue_occupancy == 4'h0;
	assign q_push_data = xfer_push ? mem_rdata[`TU_CNT_W-1:0] : reg_wdata[`TU_CNT_W-1:0];
	assign q_push = !flush && !q_full && (xfer_push || (wr_queue && !input_mode));
	assign q_pop = !flush && !q_empty && (load_now || (rd_queue && input_mode));

	always_ff @(posedge clk) begin
		if (q_push)
			queue_mem[q_wr_ptr] <= q_push_data;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			q_wr_ptr <= 3'h0;
			q_rd_ptr <= 3'h0;
			queue_occupancy <= 4'h0;
		end else if (flush) begin
			q_wr_ptr <= 3'h0;
			q_rd_ptr <= 3'h0;
			queue_occupancy <= 4'h0;
		end else begin
			if (q_push)
				q_wr_ptr <= q_wr_ptr + 3'h1;
			if (q_pop)
				q_rd_ptr <= q_rd_ptr + 3'h1;
			queue_occupancy <= queue_occupancy + 4'(q_push) - 4'(q_pop);
		end
	end

	// pwm duty and repeat handling
	always_comb begin
		case (mode_control[`TU_B_REP_LO +: 2])
			2'b00: rep_limit = 4'h0;
			2'b01: rep_limit = 4'h3;
			2'b10: rep_limit = 4'h7;
			default: rep_limit = 4'hf;
		endcase
	end

	assign rep_done = !duty_valid || rep_cnt >= rep_limit;
	assign load_now = pwm_mode && ((period_hit && rep_done) || (!duty_valid && !q_empty));
	assign overrun_hit = pwm_mode && period_hit && rep_done && q_empty;
	assign level_hit = pwm_mode && run && duty_valid && duty != 26'h0000000
		&& current_tally == duty;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			duty <= 26'h0000000;
			duty_valid <= 1'b0;
			rep_cnt <= 4'h0;
		end else if (flush) begin
			duty_valid <= 1'b0;
			rep_cnt <= 4'h0;
		end else begin
			if (load_now && !q_empty) begin
				duty <= queue_mem[q_rd_ptr];
				duty_valid <= 1'b1;
			end
			if (period_hit && pwm_mode)
				rep_cnt <= rep_done ? 4'h0 : rep_cnt + 4'h1;
		end
	end

	// active while tally in 1..duty, so one clock per duty step
	assign active_level = run && duty_valid && current_tally != 26'h0000000
		&& current_tally <= duty;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wave_pin_out <= 1'b0;
			wave_pin_oe <= 1'b0;
		end else begin
			wave_pin_out <= (pwm_mode && run && active_level) ? !polarity : polarity;
			wave_pin_oe <= !input_mode && out_on;
		end
	end

	// flags: hardware set wins over software clear
	assign flag_set = {overrun_hit,
		xfer_push && xfer_last,
		pwm_mode && queue_occupancy < `TU_Q_HALF,
		level_hit,
		period_hit || count_hit};

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			flag_register <= 5'h00;
		else if (flush)
			flag_register <= 5'h00;
		else
			flag_register <= (flag_register & ~(wr_flags ? reg_wdata[4:0] : 5'h00)) | flag_set;
	end

	assign irq = |(flag_register & irq_enable_register);

	// refill engine
	assign next_pointer = transfer_pointer + `TU_WORD_STEP;
	assign xfer_last = next_pointer == buffer_limit;
	assign xfer_push = HAS_XFER && xfer_state == timer_unit_pkg::xfer_wait && mem_valid;
	assign xfer_issue = HAS_XFER && transfer_control[`TU_X_ON] && !xfer_stopped && !flush
		&& xfer_state == timer_unit_pkg::xfer_idle && !wr_xctl
		&& !q_full && transfer_pointer != buffer_limit;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			transfer_control <= 3'h0;
			buffer_first <= 14'h0000;
			buffer_limit <= 14'h0000;
		end else begin
			if (wr_xctl)
				transfer_control <= {reg_wdata[`TU_X_WRAP], 1'b0, reg_wdata[`TU_X_ON]};
			if (wr_first)
				buffer_first <= {reg_wdata[`TU_ADR_W-1:2], 2'b00};
			if (wr_limit)
				buffer_limit <= {reg_wdata[`TU_ADR_W-1:2], 2'b00};
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			xfer_state <= timer_unit_pkg::xfer_idle;
			transfer_pointer <= 14'h0000;
			xfer_stopped <= 1'b0;
			mem_rd <= 1'b0;
			mem_addr <= 14'h0000;
		end else begin
			mem_rd <= 1'b0;
			if (wr_xctl && reg_wdata[`TU_X_ON]) begin
				transfer_pointer <= buffer_first;
				xfer_stopped <= 1'b0;
			end
			case (xfer_state)
				timer_unit_pkg::xfer_idle: begin
					if (xfer_issue) begin
						mem_rd <= 1'b1;
						mem_addr <= transfer_pointer;
						xfer_state <= timer_unit_pkg::xfer_wait;
					end
				end
				timer_unit_pkg::xfer_wait: begin
					if (mem_valid) begin
						xfer_state <= timer_unit_pkg::xfer_idle;
						if (!xfer_last)
							transfer_pointer <= next_pointer;
						else if (transfer_control[`TU_X_WRAP])
							transfer_pointer <= buffer_first;
						else begin
							transfer_pointer <= next_pointer;
							xfer_stopped <= 1'b1;
						end
					end
				end
				default: xfer_state <= timer_unit_pkg::xfer_idle;
			endcase
		end
	end

	// read port, data one cycle after the strobe; queue read in input modes pops
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			reg_rdata <= 32'h00000000;
		else if (reg_rd) begin
			case (reg_addr)
				`TU_OFS_MODE: reg_rdata <= {22'h000000, mode_control};
				`TU_OFS_IRQ_EN: reg_rdata <= {27'h0000000, irq_enable_register};
				`TU_OFS_FLAGS: reg_rdata <= {27'h0000000, flag_register};
				`TU_OFS_OCCUPANCY: reg_rdata <= {28'h0000000, queue_occupancy};
				`TU_OFS_TALLY: reg_rdata <= {6'h00, current_tally};
				`TU_OFS_TERMINAL: reg_rdata <= {6'h00, terminal_value};
				`TU_OFS_QUEUE: reg_rdata <= {6'h00, q_empty ? 26'h0000000 : queue_mem[q_rd_ptr]};
				`TU_OFS_XFER_CTL: reg_rdata <= {29'h00000000, transfer_control};
				`TU_OFS_XFER_PTR: reg_rdata <= {18'h00000, transfer_pointer};
				`TU_OFS_BUF_FIRST: reg_rdata <= {18'h00000, buffer_first};
				`TU_OFS_BUF_LIMIT: reg_rdata <= {18'h00000, buffer_limit};
				default: reg_rdata <= 32'h00000000;
			endcase
		end else
			reg_rdata <= 32'h00000000;
	end

	sequence s_last_word;
		xfer_push && xfer_last;
	endsequence

	property p_term_write_clears;
		@(posedge clk) disable iff (!resetn) wr_term |=> current_tally == 26'h0000000;
	endproperty
	a_term_write_clears: assert property (p_term_write_clears) else $error("tally not cleared");
	property p_period_flag;
		@(posedge clk) disable iff (!resetn) (period_hit && !flush) |=> flag_register[`TU_F_PERIOD];
	endproperty
	a_period_flag: assert property (p_period_flag) else $error("period flag missing");
	property p_count_wrap;
		@(posedge clk) disable iff (!resetn)
			(count_hit && !wr_term && !wr_mode) |=> current_tally == 26'h0000000
			&& flag_register[`TU_F_PERIOD];
	endproperty
	a_count_wrap: assert property (p_count_wrap) else $error("count wrap wrong");
	property p_flush_empties;
		@(posedge clk) disable iff (!resetn)
			flush |=> queue_occupancy == 4'h0 && current_tally == 26'h0000000;
	endproperty
	a_flush_empties: assert property (p_flush_empties) else $error("flush incomplete");
	property p_occupancy_bound;
		@(posedge clk) disable iff (!resetn) queue_occupancy <= 4'(`TU_Q_DEPTH);
	endproperty
	a_occupancy_bound: assert property (p_occupancy_bound) else $error("queue overfilled");
	property p_idle_level;
		@(posedge clk) disable iff (!resetn)
			!(run && out_on) |=> wave_pin_out == $past(polarity);
	endproperty
	a_idle_level: assert property (p_idle_level) else $error("idle level wrong");
	property p_pointer_step;
		@(posedge clk) disable iff (!resetn)
			(xfer_push && !xfer_last && !wr_xctl) |=> transfer_pointer == $past(next_pointer);
	endproperty
	a_pointer_step: assert property (p_pointer_step) else $error("pointer step wrong");
	property p_wrap_reload;
		@(posedge clk) disable iff (!resetn)
			(s_last_word ##0 (transfer_control[`TU_X_WRAP] && !wr_xctl))
			|=> transfer_pointer == $past(buffer_first);
	endproperty
	a_wrap_reload: assert property (p_wrap_reload) else $error("wrap reload missing");
	property p_halt_at_limit;
		@(posedge clk) disable iff (!resetn)
			(s_last_word ##0 !transfer_control[`TU_X_WRAP])
			|=> (!mem_rd && flag_register[`TU_F_XFER]) || $past(wr_xctl) || flush;
	endproperty
	a_halt_at_limit: assert property (p_halt_at_limit) else $error("engine did not halt");
endmodule : timer_pwm_dma_unit

//--- testbench/mem_model.sv
// memory responder for the refill engine, variable latency
`timescale 1ns/100ps

module mem_model (
	input wire logic clk,
	input wire logic resetn,
	input wire logic mem_rd,
	input wire logic [13:0] mem_addr,
	output logic mem_valid,
	output logic [31:0] mem_rdata,
	output int reads
);
	int wait_left;
	int lat;
	logic [13:0] addr_q;

	// one read outstanding, latency 1..3 cycles; data bus churns when idle
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mem_valid <= 1'b0;
			mem_rdata <= 32'h0;
			wait_left <= 0;
			lat <= 0;
			reads <= 0;
			addr_q <= 14'h0;
		end else begin
			mem_valid <= 1'b0;
			mem_rdata <= ~mem_rdata;
			if (mem_rd) begin
				addr_q <= mem_addr;
				wait_left <= lat + 1;
				lat <= (lat + 1) % 3;
				reads <= reads + 1;
			end else if (wait_left == 1) begin
				mem_valid <= 1'b1;
				mem_rdata <= {18'h0, addr_q};
				wait_left <= 0;
			end else if (wait_left > 1) begin
				wait_left <= wait_left - 1;
			end
		end
	end
endmodule : mem_model

//--- testbench/testbench.sv
// self-checking bench of the timer unit
`timescale 1ns/100ps
`include "timer_unit_consts.svh"

module testbench;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [5:0] reg_addr = 6'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic count_pin_in = 1'b0;
	logic [31:0] reg_rdata, mem_rdata;
	logic wave_pin_out, wave_pin_oe, mem_rd, mem_valid, irq;
	logic [13:0] mem_addr;
	int reads, error_cnt, num_checks, cyc, t0;
	logic [31:0] seed = 32'h95af88e7;
	int exp_q[$];
	int got_q[$];

	always #50 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;

	timer_pwm_dma_unit i_timer_pwm_dma_unit (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.count_pin_in(count_pin_in), .wave_pin_out(wave_pin_out), .wave_pin_oe(wave_pin_oe),
		.mem_rd(mem_rd), .mem_addr(mem_addr), .mem_valid(mem_valid), .mem_rdata(mem_rdata),
		.irq(irq));
	mem_model i_mem_model (.clk(clk), .resetn(resetn), .mem_rd(mem_rd), .mem_addr(mem_addr),
		.mem_valid(mem_valid), .mem_rdata(mem_rdata), .reads(reads));

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	task automatic wrap_up();
		if (error_cnt == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk

	task automatic tmo(input int n);
		if (n > 5000) begin
			chk("timeout", 32'h0, 32'h1);
			wrap_up();
		end
	endtask : tmo

	task automatic wr(input logic [5:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr

	task automatic rchk(input string nm, input logic [5:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(nm, e, reg_rdata);
	endtask : rchk

	task automatic cycles(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cycles

	task automatic wait_irq();
		int n;
		n = 0;
		while (irq !== 1'b1) begin
			@(posedge clk);
			#1 n++;
			tmo(n);
		end
	endtask : wait_irq

	// pulses three clocks high and four low, then let the synchroniser settle
	task automatic pulses(input int n);
		repeat (n) begin
			@(posedge clk);
			count_pin_in <= 1'b1;
			repeat (3) @(posedge clk);
			count_pin_in <= 1'b0;
			repeat (3) @(posedge clk);
		end
		cycles(5);
	endtask : pulses

	initial begin
		int e, k, r, run, reps;
		logic pol;
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		rchk("mode", `TU_OFS_MODE, 32'h2);
		rchk("unmapped", 6'h3c, 32'h0);
		wr(`TU_OFS_TERMINAL, 32'hffffffff);
		rchk("terminal", `TU_OFS_TERMINAL, 32'h3ffffff);
		wr(`TU_OFS_TERMINAL, 32'd10);
		wr(`TU_OFS_IRQ_EN, 32'h1);
		wr(`TU_OFS_MODE, 32'h4);
		wait_irq();
		t0 = cyc;
		wr(`TU_OFS_FLAGS, 32'h1);
		wait_irq();
		chk("period", 32'd10, cyc - t0);
		wr(`TU_OFS_MODE, 32'h0);
		wr(`TU_OFS_IRQ_EN, 32'h0);
		wr(`TU_OFS_FLAGS, 32'h1);
		rchk("flag_clear", `TU_OFS_FLAGS, 32'h0);
		wr(`TU_OFS_TERMINAL, 32'd1000);
		wr(`TU_OFS_MODE, 32'h4);
		cycles(20);
		wr(`TU_OFS_TERMINAL, 32'd1000);
		rchk("tally_clear", `TU_OFS_TALLY, 32'h1);
		wr(`TU_OFS_MODE, 32'h2);
		rchk("flush_tally", `TU_OFS_TALLY, 32'h0);
		// each sampling edge choice, two pulses
		for (e = 0; e < 4; e++) begin
			wr(`TU_OFS_MODE, 32'h2);
			wr(`TU_OFS_MODE, 32'h25 | (e << 6));
			pulses(2);
			k = (e == 0) ? 0 : (e == timer_unit_pkg::edge_both) ? 4 : 2;
			rchk("edges", `TU_OFS_TALLY, k);
		end
		wr(`TU_OFS_MODE, 32'h2);
		wr(`TU_OFS_TERMINAL, 32'd3);
		wr(`TU_OFS_MODE, 32'he5);
		pulses(4);
		rchk("tally4", `TU_OFS_TALLY, 32'd4);
		rchk("no_flag", `TU_OFS_FLAGS, 32'h0);
		pulses(1);
		rchk("wrap", `TU_OFS_TALLY, 32'd0);
		rchk("wrap_flag", `TU_OFS_FLAGS, 32'h1);
		wr(`TU_OFS_MODE, 32'h2);
		wr(`TU_OFS_MODE, 32'h0);
		repeat (9) wr(`TU_OFS_QUEUE, 32'd3);
		rchk("full", `TU_OFS_OCCUPANCY, 32'd8);
		wr(`TU_OFS_TERMINAL, 32'd8);
		// every repeat code, polarity alternating
		for (r = 0; r < 4; r++) begin
			pol = r[0];
			reps = (r == 0) ? 1 : 4 << (r - 1);
			wr(`TU_OFS_MODE, 32'h2);
			wr(`TU_OFS_MODE, 32'({r[1:0], 3'b000, pol, 4'h8}));
			exp_q.delete();
			got_q.delete();
			repeat (2) begin
				k = xs() % 7 + 1;
				wr(`TU_OFS_QUEUE, k);
				repeat (reps) exp_q.push_back(k);
			end
			cycles(2);
			chk("idle", 32'(pol), 32'(wave_pin_out));
			chk("oe", 32'h1, 32'(wave_pin_oe));
			wr(`TU_OFS_MODE, 32'({r[1:0], 3'b000, pol, 4'hc}));
			run = 0;
			k = 0;
			while (got_q.size() < exp_q.size()) begin
				@(posedge clk);
				#1 k++;
				tmo(k);
				if (wave_pin_out !== pol) begin
					run++;
				end else if (run > 0) begin
					got_q.push_back(run);
					run = 0;
				end
			end
			for (k = 0; k < exp_q.size(); k++) begin
				chk("active_len", exp_q[k], got_q[k]);
			end
			cycles(10);
			rchk("pwm_flags", `TU_OFS_FLAGS, 32'h17);
		end
		wr(`TU_OFS_MODE, 32'h2);
		wr(`TU_OFS_MODE, 32'h0);
		wr(`TU_OFS_BUF_FIRST, 32'hfff0);
		rchk("first", `TU_OFS_BUF_FIRST, 32'h3ff0);
		wr(`TU_OFS_BUF_FIRST, 32'h100);
		wr(`TU_OFS_BUF_LIMIT, 32'h110);
		t0 = reads;
		wr(`TU_OFS_XFER_CTL, 32'h1);
		cycles(60);
		rchk("pointer", `TU_OFS_XFER_PTR, 32'h110);
		rchk("words", `TU_OFS_OCCUPANCY, 32'd4);
		chk("reads", 32'd4, reads - t0);
		wr(`TU_OFS_MODE, 32'h1);
		rchk("queue_head", `TU_OFS_QUEUE, 32'h100);
		rchk("queue_next", `TU_OFS_QUEUE, 32'h104);
		rchk("occ_after", `TU_OFS_OCCUPANCY, 32'd2);
		rchk("done", `TU_OFS_FLAGS, 32'h8);
		wr(`TU_OFS_IRQ_EN, 32'h8);
		chk("irq", 32'h1, 32'(irq));
		wr(`TU_OFS_FLAGS, 32'h8);
		chk("irq_clear", 32'h0, 32'(irq));
		rchk("done_clear", `TU_OFS_FLAGS, 32'h0);
		wr(`TU_OFS_MODE, 32'h2);
		wr(`TU_OFS_MODE, 32'h0);
		wr(`TU_OFS_BUF_LIMIT, 32'h108);
		t0 = reads;
		wr(`TU_OFS_XFER_CTL, 32'h5);
		cycles(80);
		rchk("refill", `TU_OFS_OCCUPANCY, 32'd8);
		chk("wrap_reads", 32'd8, reads - t0);
		rchk("wrap_ptr", `TU_OFS_XFER_PTR, 32'h100);
		wrap_up();
	end
endmodule : testbench
